/* File: dmacsf_pkg.sv */
package dmacsf_pkg;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_PEND = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

    // channel layout: four flags per channel, channel 0 at bit 0
    localparam int NUM_CH = 8;
    localparam int CH_BITS = 4;
    localparam int FLD_ANY = 0;
    localparam int FLD_DONE = 1;
    localparam int FLD_HALF = 2;
    localparam int FLD_ERR = 3;

    // flag positions held by this slice
    localparam int CHAN2_ERROR_FLAG = 11;
    localparam int CHAN3_ANY_EVENT_FLAG = 12;
    localparam int CHAN3_DONE_FLAG = 13;
    localparam int CHAN3_HALFWAY_FLAG = 14;
    localparam int CHAN3_ERROR_FLAG = 15;
    localparam int CHAN4_ANY_EVENT_FLAG = 16;
    localparam int CHAN4_DONE_FLAG = 17;
    localparam int CHAN4_HALFWAY_FLAG = 18;
    localparam int CHAN4_ERROR_FLAG = 19;
    localparam int CHAN5_ANY_EVENT_FLAG = 20;

    // bits 11..20 are implemented, all others read as zero
    localparam logic [DATA_W-1:0] SLICE_MASK = 32'h001F_F800;
    localparam logic [DATA_W-1:0] RESET_FLAGS = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RESET_MASK = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // per-channel strobes from the transfer engine
    typedef struct packed {
        logic transferDoneEvent;
        logic halfwayEvent;
        logic transferErrorEvent;
    } dmacsf_evt_t;

    // register port request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dmacsf_req_t;

endpackage : dmacsf_pkg

/* File: dmacsf_status_flags.sv */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dmacsf_status_flags (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // channel event strobes, one-cycle pulses
    input wire dmacsf_pkg::dmacsf_evt_t [dmacsf_pkg::NUM_CH-1:0] chanEvent,
    // register port
    input wire dmacsf_pkg::dmacsf_req_t busReq,
    output logic [dmacsf_pkg::DATA_W-1:0] rdData_r,
    // interrupt and flag view
    output logic irq_r,
    output logic [dmacsf_pkg::DATA_W-1:0] statusFlag_r
);

    logic [dmacsf_pkg::DATA_W-1:0] setBits;
    logic [dmacsf_pkg::DATA_W-1:0] clrBits;
    logic [dmacsf_pkg::DATA_W-1:0] statusFlag_nxt;
    logic [dmacsf_pkg::DATA_W-1:0] irqPend_r;
    logic [dmacsf_pkg::DATA_W-1:0] irqPend_nxt;
    logic [dmacsf_pkg::DATA_W-1:0] irqMask_r;
    logic [dmacsf_pkg::DATA_W-1:0] rdMux;
    wire hitStatus = busReq.addr == dmacsf_pkg::OFS_STATUS;
    wire hitClear = busReq.addr == dmacsf_pkg::OFS_CLEAR;
    wire hitPend = busReq.addr == dmacsf_pkg::OFS_IRQ_PEND;
    wire hitMask = busReq.addr == dmacsf_pkg::OFS_IRQ_MASK;
    wire clrWrite = busReq.wrEn && hitClear;
    wire pendRead = busReq.rdEn && hitPend;

    // per-channel set and clear terms in the shared four-bit layout
    for (genvar c = 0; c < dmacsf_pkg::NUM_CH; c++) begin : g_chan
        localparam int B = c * dmacsf_pkg::CH_BITS;
        wire grpClr = clrWrite && busReq.wdata[B + dmacsf_pkg::FLD_ANY];
        assign setBits[B + dmacsf_pkg::FLD_DONE] =
            chanEvent[c].transferDoneEvent;
        assign setBits[B + dmacsf_pkg::FLD_HALF] =
            chanEvent[c].halfwayEvent;
        assign setBits[B + dmacsf_pkg::FLD_ERR] =
            chanEvent[c].transferErrorEvent;
        // any-event follows all three strobes
        assign setBits[B + dmacsf_pkg::FLD_ANY] =
            chanEvent[c].transferDoneEvent | chanEvent[c].halfwayEvent |
            chanEvent[c].transferErrorEvent;
        // a one on the any-event clear bit sweeps the whole group
        for (genvar f = 0; f < dmacsf_pkg::CH_BITS; f++) begin : g_fld
            assign clrBits[B + f] =
                grpClr || (clrWrite && busReq.wdata[B + f]);
        end
    end

    // set dominates clear so a coincident event is never lost
    assign statusFlag_nxt = ((statusFlag_r & ~clrBits) | setBits) &
        dmacsf_pkg::SLICE_MASK;
    // pending bits record new flag events; a read clears, set still wins
    assign irqPend_nxt = ((pendRead ? dmacsf_pkg::ZERO_WORD : irqPend_r) |
        setBits) & dmacsf_pkg::SLICE_MASK;
    // read selection; unmapped addresses and the clear register read zero
    assign rdMux = hitStatus ? statusFlag_r :
        hitPend ? irqPend_r :
        hitMask ? irqMask_r : dmacsf_pkg::ZERO_WORD;

    // flags: only hardware sets, status writes are not decoded
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            statusFlag_r <= dmacsf_pkg::RESET_FLAGS;
        end else begin
            statusFlag_r <= statusFlag_nxt;
        end
    end

    // interrupt pending, mask and output
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irqPend_r <= dmacsf_pkg::RESET_FLAGS;
            irqMask_r <= dmacsf_pkg::RESET_MASK;
            irq_r <= 1'b0;
        end else begin
            irqPend_r <= irqPend_nxt;
            if (busReq.wrEn && hitMask) begin
                irqMask_r <= busReq.wdata & dmacsf_pkg::SLICE_MASK;
            end
            irq_r <= |(irqPend_r & irqMask_r); // one cycle behind pending
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdData_r <= dmacsf_pkg::ZERO_WORD;
        end else begin
            rdData_r <= busReq.rdEn ? rdMux : dmacsf_pkg::ZERO_WORD;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // flags come out of reset clear
    property p_reset_clear;
        !$past(reset_n) |-> statusFlag_r == dmacsf_pkg::RESET_FLAGS;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags not zero after reset");

    // a status write with no events changes nothing
    property p_status_write_ignored;
        busReq.wrEn && hitStatus && chanEvent == '0 |=>
            statusFlag_r == $past(statusFlag_r);
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored)
        else $error("status write altered flags");

    // single-bit clear drops the flag next cycle
    property p_clear_bit;
        clrWrite && busReq.wdata[dmacsf_pkg::CHAN2_ERROR_FLAG] &&
            !chanEvent[2].transferErrorEvent |=>
            !statusFlag_r[dmacsf_pkg::CHAN2_ERROR_FLAG];
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("clear write left flag set");

    property p_ch2_error;
        chanEvent[2].transferErrorEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN2_ERROR_FLAG];
    endproperty
    a_ch2_error: assert property (p_ch2_error)
        else $error("channel 2 error flag not set");

    property p_ch3_any;
        chanEvent[3] != '0 |=>
            statusFlag_r[dmacsf_pkg::CHAN3_ANY_EVENT_FLAG];
    endproperty
    a_ch3_any: assert property (p_ch3_any)
        else $error("channel 3 any-event flag not set");

    // a half event alone sets only half and any on channel 3
    property p_ch3_half_only;
        statusFlag_r[dmacsf_pkg::CHAN3_ERROR_FLAG:
            dmacsf_pkg::CHAN3_ANY_EVENT_FLAG] == 4'h0 &&
            chanEvent[3].halfwayEvent && !chanEvent[3].transferDoneEvent &&
            !chanEvent[3].transferErrorEvent && !clrWrite |=>
            statusFlag_r[dmacsf_pkg::CHAN3_ANY_EVENT_FLAG] &&
            statusFlag_r[dmacsf_pkg::CHAN3_HALFWAY_FLAG] &&
            !statusFlag_r[dmacsf_pkg::CHAN3_DONE_FLAG] &&
            !statusFlag_r[dmacsf_pkg::CHAN3_ERROR_FLAG];
    endproperty
    a_ch3_half_only: assert property (p_ch3_half_only)
        else $error("channel 3 half event set wrong bits");

    property p_ch4_any;
        chanEvent[4].halfwayEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN4_ANY_EVENT_FLAG];
    endproperty
    a_ch4_any: assert property (p_ch4_any)
        else $error("channel 4 any-event flag not set");

    property p_ch4_error;
        chanEvent[4].transferErrorEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN4_ERROR_FLAG] ##1
            statusFlag_r[dmacsf_pkg::CHAN4_ERROR_FLAG] ||
            $past(clrWrite && (busReq.wdata[dmacsf_pkg::CHAN4_ERROR_FLAG] ||
            busReq.wdata[dmacsf_pkg::CHAN4_ANY_EVENT_FLAG]));
    endproperty
    a_ch4_error: assert property (p_ch4_error)
        else $error("channel 4 error flag not held");

    property p_ch5_any;
        chanEvent[5].transferDoneEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN5_ANY_EVENT_FLAG];
    endproperty
    a_ch5_any: assert property (p_ch5_any)
        else $error("channel 5 any-event flag not set");

    property p_group_clear;
        clrWrite && busReq.wdata[dmacsf_pkg::CHAN3_ANY_EVENT_FLAG] &&
            chanEvent[3] == '0 |=> statusFlag_r[dmacsf_pkg::CHAN3_ERROR_FLAG:
            dmacsf_pkg::CHAN3_ANY_EVENT_FLAG] == 4'h0;
    endproperty
    a_group_clear: assert property (p_group_clear)
        else $error("group clear left channel 3 flags");

    property p_outside_slice;
        (statusFlag_r & ~dmacsf_pkg::SLICE_MASK) == dmacsf_pkg::ZERO_WORD;
    endproperty
    a_outside_slice: assert property (p_outside_slice)
        else $error("bit outside slice set");

    property p_set_wins;
        chanEvent[3].transferDoneEvent && clrWrite &&
            busReq.wdata[dmacsf_pkg::CHAN3_DONE_FLAG] |=>
            statusFlag_r[dmacsf_pkg::CHAN3_DONE_FLAG];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to clear");

    // channel 3 and 4 strobes land on their own bit next cycle; channel 5 error and half land on its any-event bit
    property p_ch3_done;
        chanEvent[3].transferDoneEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN3_DONE_FLAG];
    endproperty
    a_ch3_done: assert property (p_ch3_done)
        else $error("channel 3 done flag not set");

    property p_ch3_error;
        chanEvent[3].transferErrorEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN3_ERROR_FLAG];
    endproperty
    a_ch3_error: assert property (p_ch3_error)
        else $error("channel 3 error flag not set");

    property p_ch4_done;
        chanEvent[4].transferDoneEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN4_DONE_FLAG];
    endproperty
    a_ch4_done: assert property (p_ch4_done)
        else $error("channel 4 done flag not set");

    property p_ch5_any_other;
        chanEvent[5].transferErrorEvent || chanEvent[5].halfwayEvent |=>
            statusFlag_r[dmacsf_pkg::CHAN5_ANY_EVENT_FLAG];
    endproperty
    a_ch5_any_other: assert property (p_ch5_any_other)
        else $error("channel 5 any-event flag missed an event");

    // with no strobe a clear flag must stay clear
    property p_ch3_done_quiet;
        !statusFlag_r[dmacsf_pkg::CHAN3_DONE_FLAG] &&
            !chanEvent[3].transferDoneEvent |=>
            !statusFlag_r[dmacsf_pkg::CHAN3_DONE_FLAG];
    endproperty
    a_ch3_done_quiet: assert property (p_ch3_done_quiet)
        else $error("channel 3 done flag set with no event");

    // flags are sticky until a clear write
    property p_ch2_error_sticky;
        statusFlag_r[dmacsf_pkg::CHAN2_ERROR_FLAG] && !clrWrite |=>
            statusFlag_r[dmacsf_pkg::CHAN2_ERROR_FLAG];
    endproperty
    a_ch2_error_sticky: assert property (p_ch2_error_sticky)
        else $error("channel 2 error flag dropped without clear");

    // zeros in the clear word leave channel 4 alone
    property p_zero_clear_kept;
        clrWrite && busReq.wdata[dmacsf_pkg::CHAN4_ERROR_FLAG:
            dmacsf_pkg::CHAN4_ANY_EVENT_FLAG] == 4'h0 && chanEvent[4] == '0
            |=> $stable(statusFlag_r[dmacsf_pkg::CHAN4_ERROR_FLAG:
            dmacsf_pkg::CHAN4_ANY_EVENT_FLAG]);
    endproperty
    a_zero_clear_kept: assert property (p_zero_clear_kept)
        else $error("zero clear bits changed channel 4 flags");

    // the any-event clear bit sweeps channel 4 as well
    property p_group_clear_ch4;
        clrWrite && busReq.wdata[dmacsf_pkg::CHAN4_ANY_EVENT_FLAG] &&
            chanEvent[4] == '0 |=> statusFlag_r[dmacsf_pkg::CHAN4_ERROR_FLAG:
            dmacsf_pkg::CHAN4_ANY_EVENT_FLAG] == 4'h0;
    endproperty
    a_group_clear_ch4: assert property (p_group_clear_ch4)
        else $error("group clear left channel 4 flags");

    // a status read returns the flags as they stood at the strobe
    property p_status_read;
        busReq.rdEn && hitStatus |=>
            rdData_r == $past(statusFlag_r);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong word");

    // read data is zero outside the reply cycle
    property p_read_idle;
        !busReq.rdEn |=> rdData_r == dmacsf_pkg::ZERO_WORD;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data outside reply cycle");

    // mask keeps only the implemented bits
    property p_mask_write;
        busReq.wrEn && hitMask |=>
            irqMask_r == ($past(busReq.wdata) & dmacsf_pkg::SLICE_MASK);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write stored wrong bits");

    // an event marks pending even against a pending read
    property p_pend_set;
        chanEvent[3].halfwayEvent |=>
            irqPend_r[dmacsf_pkg::CHAN3_HALFWAY_FLAG] &&
            irqPend_r[dmacsf_pkg::CHAN3_ANY_EVENT_FLAG];
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("pending bits missed a channel 3 event");

    // a pending read with no events empties the pending word
    property p_pend_read_clear;
        pendRead && chanEvent == '0 |=>
            irqPend_r == dmacsf_pkg::ZERO_WORD;
    endproperty
    a_pend_read_clear: assert property (p_pend_read_clear)
        else $error("pending read left bits set");

    // line follows unmasked pending one cycle later
    property p_irq_on;
        (irqPend_r & irqMask_r) != dmacsf_pkg::ZERO_WORD |=>
            irq_r;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("interrupt line missed unmasked pending bit");

    property p_irq_off;
        (irqPend_r & irqMask_r) == dmacsf_pkg::ZERO_WORD |=>
            !irq_r;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt line high with nothing pending");

endmodule : dmacsf_status_flags

/* File: dmacsf_status_flags_tb_top.sv */
`timescale 1ns/1ps
module dmacsf_status_flags_tb_top;
    // design ports
    logic clk_sys;
    logic reset_n;
    dmacsf_pkg::dmacsf_evt_t [dmacsf_pkg::NUM_CH-1:0] chanEvent;
    dmacsf_pkg::dmacsf_req_t busReq;
    logic [31:0] rdData_r;
    logic irq_r;
    logic [31:0] statusFlag_r;
    // bookkeeping
    int nErrors = 0;
    int nChecks = 0;
    int cycles = 0;

    dmacsf_status_flags DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .chanEvent(chanEvent),
        .busReq(busReq), .rdData_r(rdData_r), .irq_r(irq_r),
        .statusFlag_r(statusFlag_r)
    );

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write; idle cycle after so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        busReq <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        busReq <= '0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        busReq <= {1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk_sys);
        busReq <= '0;
        #1 chk(rdData_r, exp);
    endtask : rd

    function automatic dmacsf_pkg::dmacsf_evt_t evt(input int f);
        evt = '0;
        evt.transferDoneEvent = (f == dmacsf_pkg::FLD_DONE);
        evt.halfwayEvent = (f == dmacsf_pkg::FLD_HALF);
        evt.transferErrorEvent = (f == dmacsf_pkg::FLD_ERR);
    endfunction : evt

    // expected view: any-event bit plus own bit, only inside the slice
    function automatic logic [31:0] flg(input int c, input int f);
        flg = (32'h0000_0001 << (4 * c)) | (32'h0000_0001 << (4 * c + f));
        flg = flg & dmacsf_pkg::SLICE_MASK;
    endfunction : flg

    // pulse one event; flag is settled when this returns
    task automatic ev(input int c, input int f);
        @(posedge clk_sys);
        chanEvent[c] <= evt(f);
        @(posedge clk_sys);
        chanEvent <= '0;
        #1;
    endtask : ev

    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // hang guard, far above the roughly 140 cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nErrors++;
            summarize();
        end
    end

    initial begin
        reset_n <= 1'b0;
        chanEvent <= '0;
        busReq <= '0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(dmacsf_pkg::OFS_STATUS, dmacsf_pkg::RESET_FLAGS);
        rd(dmacsf_pkg::OFS_IRQ_PEND, 32'h0000_0000);
        rd(dmacsf_pkg::OFS_IRQ_MASK, dmacsf_pkg::RESET_MASK);
        $display("test reset done");
        wr(dmacsf_pkg::OFS_IRQ_MASK, 32'hFFFF_FFFF);
        rd(dmacsf_pkg::OFS_IRQ_MASK, dmacsf_pkg::SLICE_MASK);
        wr(dmacsf_pkg::OFS_IRQ_MASK, 32'h0000_1000);
        ev(3, dmacsf_pkg::FLD_HALF);
        chk(statusFlag_r, 32'h0000_5000);
        @(posedge clk_sys);
        #1 chk({31'h0, irq_r}, 32'h0000_0001);
        rd(dmacsf_pkg::OFS_IRQ_PEND, 32'h0000_5000);
        rd(dmacsf_pkg::OFS_IRQ_PEND, 32'h0000_0000);
        // pending word is read-clear only, writes must not set it
        wr(dmacsf_pkg::OFS_IRQ_PEND, 32'hFFFF_FFFF);
        rd(dmacsf_pkg::OFS_IRQ_PEND, 32'h0000_0000);
        @(posedge clk_sys);
        #1 chk({31'h0, irq_r}, 32'h0000_0000);
        wr(dmacsf_pkg::OFS_CLEAR, 32'h0000_1000);
        #1 chk(statusFlag_r, 32'h0000_0000);
        // masked-out channel must not raise the line
        ev(4, dmacsf_pkg::FLD_DONE);
        @(posedge clk_sys);
        #1 chk({31'h0, irq_r}, 32'h0000_0000);
        wr(dmacsf_pkg::OFS_CLEAR, 32'h0001_0000);
        $display("test interrupt done");
        // every event kind on every channel reaching the slice
        for (int c = 2; c <= 5; c++) begin
            for (int f = 1; f <= 3; f++) begin
                ev(c, f);
                chk(statusFlag_r, flg(c, f));
                rd(dmacsf_pkg::OFS_STATUS, flg(c, f));
                wr(dmacsf_pkg::OFS_CLEAR, 32'h0000_000F << (4 * c));
                #1 chk(statusFlag_r, 32'h0000_0000);
            end
        end
        $display("test event map done");
        ev(4, dmacsf_pkg::FLD_ERR);
        wr(dmacsf_pkg::OFS_STATUS, 32'h0000_0000);
        #1 chk(statusFlag_r, 32'h0009_0000);
        wr(dmacsf_pkg::OFS_CLEAR, 32'h0000_0000);
        #1 chk(statusFlag_r, 32'h0009_0000);
        wr(dmacsf_pkg::OFS_CLEAR, 32'h0008_0000);
        #1 chk(statusFlag_r, 32'h0001_0000);
        wr(dmacsf_pkg::OFS_CLEAR, 32'h0001_0000);
        rd(dmacsf_pkg::OFS_CLEAR, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        $display("test clear paths done");
        // event and whole-channel clear land on the same edge
        ev(3, dmacsf_pkg::FLD_HALF);
        @(posedge clk_sys);
        chanEvent[3] <= evt(dmacsf_pkg::FLD_DONE);
        busReq <= {1'b1, 1'b0, dmacsf_pkg::OFS_CLEAR, 32'h0000_F000};
        @(posedge clk_sys);
        chanEvent <= '0;
        busReq <= '0;
        #1 chk(statusFlag_r, 32'h0000_3000);
        $display("test collision done");
        summarize();
    end
endmodule : dmacsf_status_flags_tb_top
